// *** common/rbt_pkg.sv ***
// ==========================================================================
// Shared constants for the registered bus transceiver
package rbt_pkg;

  // ========================================================================
  // Widths and depths
  localparam int RBT_BUS_WIDTH = 8;
  localparam int RBT_FIFO_DEPTH = 16;

  // ========================================================================
  // Clocking and synchroniser figures
  localparam int RBT_CORE_CLK_MHZ = 200;
  localparam real RBT_CORE_PERIOD_NS = 1000.0 / RBT_CORE_CLK_MHZ;
  localparam int RBT_SYNC_STAGES = 2;

  // ========================================================================
  // Reset values of flops facing the pins
  localparam logic RBT_RST_LEVEL = 1'h0;
  localparam logic RBT_RST_OE_N = 1'h1;
  localparam logic RBT_RST_DRIVE_EN_N = 1'h1;
  localparam logic [RBT_BUS_WIDTH-1:0] RBT_RST_BUS = 8'h00;

endpackage : rbt_pkg

// *** src/rbt_fifo.sv ***
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// Capture FIFO with a registered output stage
module rbt_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0] wr_ptr_ff;
  logic [PW-1:0] rd_ptr_ff;
  logic [CW-1:0] count_ff;
  logic out_valid_ff;
  logic [WIDTH-1:0] out_data_ff;
  logic push;
  logic pop;

  // ========================================================================
  // Handshake terms
  assign in_ready = (count_ff != CW'(DEPTH));
  assign push = in_valid && in_ready;
  // Output stage refills whenever it is empty or being taken
  assign pop = (count_ff != '0) && (!out_valid_ff || out_ready);

  // ========================================================================
  // Storage; no reset, contents only matter once written
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == PW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == PW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end

  // ========================================================================
  // Registered output stage
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      out_valid_ff <= 1'b0;
      out_data_ff <= '0;
    end else if (pop) begin
      out_valid_ff <= 1'b1;
      out_data_ff <= mem_ff[rd_ptr_ff];
    end else if (out_ready) begin
      out_valid_ff <= 1'b0;
    end
  end

  assign out_valid = out_valid_ff;
  assign out_data = out_data_ff;

endmodule : rbt_fifo

`default_nettype wire

// *** src/rbt_transceiver.sv ***
`timescale 1ns/10ps
`default_nettype none

module rbt_transceiver
  import rbt_pkg::*;
#(
  parameter int WIDTH = RBT_BUS_WIDTH,
  parameter int FIFO_DEPTH = RBT_FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic a_to_b_capture_clock,
  input wire logic b_to_a_capture_clock,
  input wire logic drive_en_n,
  input wire logic dir,
  input wire logic a_output_source_select,
  input wire logic b_output_source_select,
  input wire logic [WIDTH-1:0] a_bus_in,
  output logic [WIDTH-1:0] a_bus_out,
  output logic a_bus_oe_n,
  input wire logic [WIDTH-1:0] b_bus_in,
  output logic [WIDTH-1:0] b_bus_out,
  output logic b_bus_oe_n,
  output logic a_to_b_captured,
  output logic b_to_a_captured,
  output logic [WIDTH-1:0] cap_data,
  output logic cap_valid,
  input wire logic cap_ready,
  output logic cap_overflow,
  input wire logic cap_overflow_clear
);

  // ========================================================================
  // Declarations
  logic [RBT_SYNC_STAGES-1:0] clk_ab_sync_ff;
  logic [RBT_SYNC_STAGES-1:0] clk_ba_sync_ff;
  logic clk_ab_prev_ff;
  logic clk_ba_prev_ff;
  logic [RBT_SYNC_STAGES-1:0] drive_en_n_sync_ff;
  logic [RBT_SYNC_STAGES-1:0] dir_sync_ff;
  logic [RBT_SYNC_STAGES-1:0] sel_a_sync_ff;
  logic [RBT_SYNC_STAGES-1:0] sel_b_sync_ff;
  logic [WIDTH-1:0] a_live;
  logic [WIDTH-1:0] b_live;
  logic [WIDTH-1:0] a_to_b_reg_ff;
  logic [WIDTH-1:0] b_to_a_reg_ff;
  logic capture_ab;
  logic capture_ba;
  logic drive_active;
  logic drive_a;
  logic drive_b;
  logic [WIDTH-1:0] nxt_a_bus_out;
  logic [WIDTH-1:0] nxt_b_bus_out;
  logic [WIDTH-1:0] a_bus_out_ff;
  logic [WIDTH-1:0] b_bus_out_ff;
  logic a_bus_oe_n_ff;
  logic b_bus_oe_n_ff;
  logic a_to_b_captured_ff;
  logic b_to_a_captured_ff;
  logic fifo_in_ready;
  logic cap_overflow_ff;

  // ========================================================================
  // Control pin synchronisers
  // Every control but cap_ready and cap_overflow_clear comes from outside core_clk, so those pass two flops
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      clk_ab_sync_ff <= '0;
      clk_ab_prev_ff <= RBT_RST_LEVEL;
    end else begin
      clk_ab_sync_ff <= {clk_ab_sync_ff[0], a_to_b_capture_clock};
      clk_ab_prev_ff <= clk_ab_sync_ff[RBT_SYNC_STAGES-1];
    end
  end

  // A capture clock high at reset release reads as an edge
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      clk_ba_sync_ff <= '0;
      clk_ba_prev_ff <= RBT_RST_LEVEL;
    end else begin
      clk_ba_sync_ff <= {clk_ba_sync_ff[0], b_to_a_capture_clock};
      clk_ba_prev_ff <= clk_ba_sync_ff[RBT_SYNC_STAGES-1];
    end
  end

  // Enable resets inactive so nothing is driven while the pipe refills
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      drive_en_n_sync_ff <= {RBT_SYNC_STAGES{RBT_RST_DRIVE_EN_N}};
    end else begin
      drive_en_n_sync_ff <= {drive_en_n_sync_ff[0], drive_en_n};
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      dir_sync_ff <= '0;
    end else begin
      dir_sync_ff <= {dir_sync_ff[0], dir};
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sel_a_sync_ff <= '0;
    end else begin
      sel_a_sync_ff <= {sel_a_sync_ff[0], a_output_source_select};
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sel_b_sync_ff <= '0;
    end else begin
      sel_b_sync_ff <= {sel_b_sync_ff[0], b_output_source_select};
    end
  end

  // ========================================================================
  // Capture edge detection
  // Edges are seen only after the second stage, so a pulse shorter than
  // a core clock period may be missed; capture clocks must be slow
  assign capture_ab = clk_ab_sync_ff[RBT_SYNC_STAGES-1] && !clk_ab_prev_ff;
  assign capture_ba = clk_ba_sync_ff[RBT_SYNC_STAGES-1] && !clk_ba_prev_ff;

  // ========================================================================
  // Per-bit channels
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_channel
      logic [RBT_SYNC_STAGES-1:0] a_sync_ff;
      logic [RBT_SYNC_STAGES-1:0] b_sync_ff;

      // Bus lines are pins, so each bit is synchronised
      always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
          a_sync_ff <= '0;
          b_sync_ff <= '0;
        end else begin
          a_sync_ff <= {a_sync_ff[0], a_bus_in[gi]};
          b_sync_ff <= {b_sync_ff[0], b_bus_in[gi]};
        end
      end

      assign a_live[gi] = a_sync_ff[RBT_SYNC_STAGES-1];
      assign b_live[gi] = b_sync_ff[RBT_SYNC_STAGES-1];

      // No reset here: stored data stays undefined until the first edge
      // Capture ignores enable, direction and selects entirely
      always_ff @(posedge core_clk) begin
        if (capture_ab) begin
          a_to_b_reg_ff[gi] <= a_live[gi];
        end
      end

      always_ff @(posedge core_clk) begin
        if (capture_ba) begin
          b_to_a_reg_ff[gi] <= b_live[gi];
        end
      end
    end
  endgenerate

  // Registers hold whenever no edge is seen, driven or not

  // ========================================================================
  // Drive direction
  // Both enables derive from one direction bit, so they can never overlap
  assign drive_active = !drive_en_n_sync_ff[RBT_SYNC_STAGES-1];
  assign drive_a = drive_active && !dir_sync_ff[RBT_SYNC_STAGES-1];
  assign drive_b = drive_active && dir_sync_ff[RBT_SYNC_STAGES-1];

  // ========================================================================
  // Output source selection
  // The live path is registered, so it lags the far bus by three cycles
  always_comb begin
    nxt_a_bus_out = b_live;
    if (sel_a_sync_ff[RBT_SYNC_STAGES-1]) begin
      nxt_a_bus_out = b_to_a_reg_ff;
    end
  end

  always_comb begin
    nxt_b_bus_out = a_live;
    if (sel_b_sync_ff[RBT_SYNC_STAGES-1]) begin
      nxt_b_bus_out = a_to_b_reg_ff;
    end
  end

  // ========================================================================
  // Bus output flops
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      a_bus_out_ff <= RBT_RST_BUS;
    end else begin
      a_bus_out_ff <= nxt_a_bus_out;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      b_bus_out_ff <= RBT_RST_BUS;
    end else begin
      b_bus_out_ff <= nxt_b_bus_out;
    end
  end

  // Both enables update on one edge, so a direction swap never overlaps
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      a_bus_oe_n_ff <= RBT_RST_OE_N;
    end else begin
      a_bus_oe_n_ff <= !drive_a;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      b_bus_oe_n_ff <= RBT_RST_OE_N;
    end else begin
      b_bus_oe_n_ff <= !drive_b;
    end
  end

  // ========================================================================
  // Capture event strobes
  // Strobes rise on the edge that loads the register
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      a_to_b_captured_ff <= 1'b0;
    end else begin
      a_to_b_captured_ff <= capture_ab;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      b_to_a_captured_ff <= 1'b0;
    end else begin
      b_to_a_captured_ff <= capture_ba;
    end
  end

  // ========================================================================
  // Captured A-to-B words stream out through the FIFO
  // Captures cannot be stalled, so a full FIFO drops the word and flags it
  rbt_fifo #(
    .WIDTH(WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) rbt_fifo_i (
    .core_clk(core_clk),
    .resetn(resetn),
    .in_valid(capture_ab),
    .in_ready(fifo_in_ready),
    .in_data(a_live),
    .out_valid(cap_valid),
    .out_ready(cap_ready),
    .out_data(cap_data)
  );

  // Set wins over a clear in the same cycle
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cap_overflow_ff <= 1'b0;
    end else if (capture_ab && !fifo_in_ready) begin
      cap_overflow_ff <= 1'b1;
    end else if (cap_overflow_clear) begin
      cap_overflow_ff <= 1'b0;
    end
  end

  // ========================================================================
  // Output assignments
  assign a_bus_out = a_bus_out_ff;
  assign b_bus_out = b_bus_out_ff;
  assign a_bus_oe_n = a_bus_oe_n_ff;
  assign b_bus_oe_n = b_bus_oe_n_ff;
  assign a_to_b_captured = a_to_b_captured_ff;
  assign b_to_a_captured = b_to_a_captured_ff;
  assign cap_overflow = cap_overflow_ff;

endmodule : rbt_transceiver

`default_nettype wire

// *** test/rbt_bus_agent.sv ***
`timescale 1ns/10ps
`default_nettype none
// ====================
// One outside bus; no keeper, so a released bus flips every cycle
module rbt_bus_agent
  import rbt_pkg::*;
(
  input wire logic core_clk,
  input wire logic drive,
  input wire logic [RBT_BUS_WIDTH-1:0] value,
  input wire logic [RBT_BUS_WIDTH-1:0] dev_out,
  input wire logic dev_oe_n,
  output logic [RBT_BUS_WIDTH-1:0] pin
);
  logic [RBT_BUS_WIDTH-1:0] last_ff = '0;
  always_ff @(posedge core_clk) last_ff <= pin;
  always_comb begin
    if (!dev_oe_n) pin = dev_out; // Agent yields to the device
    else if (drive) pin = value;
    else pin = ~last_ff;
  end
endmodule : rbt_bus_agent
`default_nettype wire

// *** test/rbt_transceiver_props.sv ***
`timescale 1ns/10ps
`default_nettype none
// ====================
// Port checks, armed once the input pipeline has refilled after reset
module rbt_transceiver_props
  import rbt_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic a_to_b_capture_clock,
  input wire logic b_to_a_capture_clock,
  input wire logic drive_en_n,
  input wire logic dir,
  input wire logic a_output_source_select,
  input wire logic b_output_source_select,
  input wire logic [RBT_BUS_WIDTH-1:0] a_bus_in,
  input wire logic [RBT_BUS_WIDTH-1:0] a_bus_out,
  input wire logic a_bus_oe_n,
  input wire logic [RBT_BUS_WIDTH-1:0] b_bus_in,
  input wire logic [RBT_BUS_WIDTH-1:0] b_bus_out,
  input wire logic b_bus_oe_n,
  input wire logic a_to_b_captured,
  input wire logic b_to_a_captured,
  input wire logic [RBT_BUS_WIDTH-1:0] cap_data,
  input wire logic cap_valid,
  input wire logic cap_ready,
  input wire logic cap_overflow,
  input wire logic cap_overflow_clear
);
  logic [2:0] up_ff;
  wire ok = &up_ff;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) up_ff <= 3'h0;
    else if (!ok) up_ff <= up_ff + 3'h1;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  AST_A_OE: assert property (ok |-> a_bus_oe_n ==
    ($past(drive_en_n, 3) | $past(dir, 3))) else $error("A enable wrong");
  AST_B_OE: assert property (ok |-> b_bus_oe_n ==
    ($past(drive_en_n, 3) | !$past(dir, 3))) else $error("B enable wrong");
  AST_ONE_BUS: assert property (ok |-> a_bus_oe_n || b_bus_oe_n)
    else $error("both buses driven");
  AST_LIVE_A: assert property (ok && !$past(drive_en_n, 3) &&
    !$past(dir, 3) && !$past(a_output_source_select, 3)
    |-> a_bus_out == $past(b_bus_in, 3)) else $error("live A wrong");
  AST_LIVE_B: assert property (ok && !$past(drive_en_n, 3) &&
    $past(dir, 3) && !$past(b_output_source_select, 3)
    |-> b_bus_out == $past(a_bus_in, 3)) else $error("live B wrong");
  AST_STR_AB: assert property (ok && $rose(a_to_b_capture_clock)
    |-> ##3 a_to_b_captured) else $error("A capture missed");
  AST_STR_BA: assert property (ok && $rose(b_to_a_capture_clock)
    |-> ##3 b_to_a_captured) else $error("B capture missed");
  AST_STORED_B: assert property (ok && a_to_b_captured ##1
    (!b_bus_oe_n && $past(b_output_source_select, 3))
    |-> b_bus_out == $past(a_bus_in, 4)) else $error("stored B wrong");
  AST_STORED_A: assert property (ok && b_to_a_captured ##1
    (!a_bus_oe_n && $past(a_output_source_select, 3))
    |-> a_bus_out == $past(b_bus_in, 4)) else $error("stored A wrong");
  AST_QUIET: assert property ((ok && $stable(a_to_b_capture_clock) &&
    $stable(b_to_a_capture_clock))[*5] |-> !a_to_b_captured &&
    !b_to_a_captured) else $error("capture without edge");
  AST_CAP_HOLD: assert property (ok && cap_valid && !cap_ready
    |=> cap_valid && $stable(cap_data)) else $error("cap word dropped");
  AST_OVF_STICKY: assert property (ok && cap_overflow && !cap_overflow_clear
    |=> cap_overflow) else $error("overflow lost");
endmodule : rbt_transceiver_props
`default_nettype wire

// *** test/rbt_transceiver_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
// ====================
// Scenario bench
module rbt_transceiver_tb
  import rbt_pkg::*;
;
  localparam int W = RBT_BUS_WIDTH;
  logic core_clk = 0, resetn = 0, drive_en_n = 1, dir = 0;
  logic a_to_b_capture_clock = 0, b_to_a_capture_clock = 0;
  logic a_output_source_select = 0, b_output_source_select = 0;
  logic cap_ready = 0, cap_overflow_clear = 0, a_drv = 1, b_drv = 1;
  logic [W-1:0] a_val = '0, b_val = '0;
  logic [W-1:0] a_bus_in, a_bus_out, b_bus_in, b_bus_out, cap_data;
  logic a_bus_oe_n, b_bus_oe_n, a_to_b_captured, b_to_a_captured;
  logic cap_valid, cap_overflow;
  int error_cnt = 0, compares = 0;
  logic [W-1:0] q[$];
  always #2.5 core_clk = ~core_clk;
  rbt_transceiver rbt_transceiver_i (
    .core_clk(core_clk),
    .resetn(resetn),
    .a_to_b_capture_clock(a_to_b_capture_clock),
    .b_to_a_capture_clock(b_to_a_capture_clock),
    .drive_en_n(drive_en_n),
    .dir(dir),
    .a_output_source_select(a_output_source_select),
    .b_output_source_select(b_output_source_select),
    .a_bus_in(a_bus_in),
    .a_bus_out(a_bus_out),
    .a_bus_oe_n(a_bus_oe_n),
    .b_bus_in(b_bus_in),
    .b_bus_out(b_bus_out),
    .b_bus_oe_n(b_bus_oe_n),
    .a_to_b_captured(a_to_b_captured),
    .b_to_a_captured(b_to_a_captured),
    .cap_data(cap_data),
    .cap_valid(cap_valid),
    .cap_ready(cap_ready),
    .cap_overflow(cap_overflow),
    .cap_overflow_clear(cap_overflow_clear)
  );
  rbt_bus_agent bus_a_i (.core_clk(core_clk), .drive(a_drv), .value(a_val),
    .dev_out(a_bus_out), .dev_oe_n(a_bus_oe_n), .pin(a_bus_in));
  rbt_bus_agent bus_b_i (.core_clk(core_clk), .drive(b_drv), .value(b_val),
    .dev_out(b_bus_out), .dev_oe_n(b_bus_oe_n), .pin(b_bus_in));
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask : wt
  task automatic chk(input string nm, input logic [W-1:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Outside party drives only the bus left as input
  task automatic ctl(input logic en_n, d, sa, sb);
    wt(1);
    drive_en_n <= en_n;
    dir <= d;
    a_output_source_select <= sa;
    b_output_source_select <= sb;
    a_drv <= en_n | d;
    b_drv <= en_n | !d;
    wt(5);
    @(negedge core_clk);
  endtask : ctl
  // Clock held static after the pulse while stored data is out
  task automatic cap(input logic ab, ba, input logic [W-1:0] va, vb);
    wt(1);
    a_val <= va;
    b_val <= vb;
    wt(3);
    a_to_b_capture_clock <= ab;
    b_to_a_capture_clock <= ba;
    wt(3);
    a_to_b_capture_clock <= 0;
    b_to_a_capture_clock <= 0;
    wt(3);
    @(negedge core_clk);
    if (ab && q.size() <= RBT_FIFO_DEPTH) q.push_back(va);
  endtask : cap
  task automatic t_iso;
    ctl(1, 0, 0, 0);
    cap(1, 1, 8'h5A, 8'hA5);
    chk("a_oe_n", a_bus_oe_n, 1);
    chk("b_oe_n", b_bus_oe_n, 1);
    wt(1);
    a_val <= 8'hFF;
    b_val <= 8'h00;
    ctl(0, 1, 0, 1);
    chk("b_stored", b_bus_out, 8'h5A);
    chk("a_oe_n", a_bus_oe_n, 1);
    ctl(0, 0, 1, 0);
    chk("a_stored", a_bus_out, 8'hA5);
    chk("b_oe_n", b_bus_oe_n, 1);
    $display("isolation test done");
  endtask : t_iso
  task automatic t_live;
    ctl(0, 0, 0, 0);
    for (int i = 0; i < 2; i++) begin
      wt(1);
      b_val <= i ? 8'hC3 : 8'h3C;
      wt(5);
      @(negedge core_clk);
      chk("a_live", a_bus_out, i ? 8'hC3 : 8'h3C);
    end
    ctl(0, 1, 0, 0);
    for (int i = 0; i < 2; i++) begin
      wt(1);
      a_val <= i ? 8'h96 : 8'h69;
      wt(5);
      @(negedge core_clk);
      chk("b_live", b_bus_out, i ? 8'h96 : 8'h69);
    end
    chk("b_oe_n", b_bus_oe_n, 0);
    $display("live test done");
  endtask : t_live
  task automatic t_store;
    for (int d = 0; d < 2; d++) begin
      ctl(0, d[0], 1, 1);
      for (int k = 0; k < 2; k++) begin
        cap(d[0], !d[0], k ? 8'hEE : 8'h11, k ? 8'hEE : 8'h11);
        chk("stored", d ? b_bus_out : a_bus_out, k ? 8'hEE : 8'h11);
      end
    end
    $display("store while driving test done");
  endtask : t_store
  task automatic t_fifo;
    ctl(1, 0, 0, 0);
    while (q.size() <= RBT_FIFO_DEPTH) cap(1, 0, W'(q.size() * 7), 8'h00);
    chk("overflow", cap_overflow, 0);
    cap(1, 0, 8'hF0, 8'h00);
    chk("overflow", cap_overflow, 1);
    wt(1);
    cap_overflow_clear <= 1;
    wt(1);
    cap_overflow_clear <= 0;
    wt(2);
    @(negedge core_clk);
    chk("overflow", cap_overflow, 0);
    while (q.size() > 0) begin
      wt(2);
      @(negedge core_clk);
      chk("cap_valid", cap_valid, 1);
      chk("cap_data", cap_data, q.pop_front());
      wt(1);
      cap_ready <= 1;
      wt(1);
      cap_ready <= 0;
    end
    wt(3);
    @(negedge core_clk);
    chk("cap_valid", cap_valid, 0);
    $display("capture buffer test done");
  endtask : t_fifo
  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done
  initial begin
    wt(4);
    resetn <= 1;
    t_iso();
    t_live();
    t_store();
    t_fifo();
    test_done();
  end
  // Whole run needs well under a thousand cycles
  initial begin
    wt(5000);
    error_cnt++;
    test_done();
  end
endmodule : rbt_transceiver_tb
bind rbt_transceiver rbt_transceiver_props rbt_transceiver_props_i (.*);
`default_nettype wire
